// >>> inc/pde_pkg.sv
package pde_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int D_W    = 8;
	localparam int E_W    = 3;

	// register byte offsets
	localparam logic [7:0] OFS_D_PIN    = 8'h00;
	localparam logic [7:0] OFS_D_LATCH  = 8'h04;
	localparam logic [7:0] OFS_D_DIR    = 8'h08;
	localparam logic [7:0] OFS_E_DIRCTL = 8'h0C;
	localparam logic [7:0] OFS_E_PIN    = 8'h10;
	localparam logic [7:0] OFS_E_LATCH  = 8'h14;
	localparam logic [7:0] OFS_PWM_CTL  = 8'h18;
	localparam logic [7:0] OFS_PWM_CFG  = 8'h1C;
	localparam logic [7:0] OFS_ANA_SEL  = 8'h20;
	localparam logic [7:0] OFS_INT_STAT = 8'h24;
	localparam logic [7:0] OFS_INT_MASK = 8'h28;

	// bank e direction and slave control fields
	localparam int E_INFULL_BIT  = 7;
	localparam int E_OUTFULL_BIT = 6;
	localparam int E_INOVF_BIT   = 5;
	localparam int E_MODE_BIT    = 4;

	// pwm control fields
	localparam int PWM_P1M_HI = 7;
	localparam int PWM_P1M_LO = 6;
	localparam int PWM_MOD_HI = 3;
	localparam int PWM_MOD_LO = 2;
	localparam logic [1:0] PWM_MODE_PWM = 2'h3;
	localparam logic [1:0] P1M_SINGLE   = 2'h0;
	localparam int PWM_B_PIN = 5;
	localparam int PWM_C_PIN = 6;
	localparam int PWM_D_PIN = 7;

	// interrupt status bits
	localparam int IRQ_OVF_BIT  = 0;
	localparam int IRQ_SHDN_BIT = 1;
	localparam int IRQ_IOP_BIT  = 2;
	localparam int IRQ_W        = 3;

	// values after reset
	localparam logic [7:0] RST_D_LATCH = 8'h00;
	localparam logic [7:0] RST_D_DIR   = 8'hFF;
	localparam logic [2:0] RST_E_DIR   = 3'h7;
	localparam logic [2:0] RST_E_LATCH = 3'h0;
	localparam logic [7:0] RST_PWM_CTL = 8'h00;
	localparam logic       RST_PWM_CFG = 1'b0;
	localparam logic [2:0] RST_ANA_SEL = 3'h7;
	localparam logic [2:0] RST_IRQ     = 3'h0;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} pde_apb_req_t;

	typedef struct packed {
		logic pwm_b;
		logic pwm_c;
		logic pwm_d;
		logic shutdown;
	} pde_pwm_in_t;

endpackage

// >>> verilog/pde_pin_cell.sv
`timescale 1ns/100ps
module pde_pin_cell (
	input  wire logic sys_clk,      // system clock
	input  wire logic rst_n,        // async reset, active low
	input  wire logic latch_bit,    // output latch bit
	input  wire logic dir_bit,      // 1 = input
	input  wire logic slave_active, // slave bus owns the pin
	input  wire logic slave_rd,     // host reading the slave bus
	input  wire logic pwm_en,       // pwm channel owns the pin
	input  wire logic pwm_val,      // pwm channel level
	input  wire logic pwm_tri,      // pwm driver floated by shutdown
	output logic      pin_o,        // pin output level
	output logic      pin_oe        // pin output enable
);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else if (pwm_en) begin
			pin_o  <= pwm_val;
			pin_oe <= ~pwm_tri;
		end else if (slave_active) begin
			pin_o  <= latch_bit;
			pin_oe <= slave_rd;
		end else begin
			pin_o  <= latch_bit;
			pin_oe <= ~dir_bit;
		end
	end

endmodule

// >>> verilog/pde_port_ctl.sv
`timescale 1ns/100ps
//Contract
// - slave bus host read drives latch out
// - slave bus host write: pins are inputs
// - pwm channels override latch and slave data
// - pwm pins optionally float during shutdown
// - gpio: direction 0 drives latch, 1 reads
// - bank e four bits, three bidirectional
// - analog bank e pins read zero
// - bank e direction 1 floats, 0 drives
// - direction controls drivers even when analog
// - upper direction bits are slave bus control
// - bank e latch read-modify-write uses latch
// - fourth e pin input only, clear shares
// - after reset pin digital only without clear
// - bank e control register bit layout
// - unimplemented bits read as zero
// - mode select bit makes bank d slave bus
// - dual or quad pwm disables slave bus
module pde_port_ctl
	import pde_pkg::*;
(
	input  wire logic              sys_clk,         // system clock, 250 MHz
	input  wire logic              rst_n,           // async reset, active low
	input  wire pde_apb_req_t      apb_req,         // apb request
	output logic                   pready,          // apb ready
	output logic [DATA_W-1:0]      prdata,          // apb read data
	output logic                   pslverr,         // apb error
	input  wire logic [D_W-1:0]    bank_d_pin_i,    // bank d pin levels
	output logic [D_W-1:0]         bank_d_pin_o,    // bank d pin drive
	output logic [D_W-1:0]         bank_d_pin_oe,   // bank d drive enable
	input  wire logic [E_W-1:0]    bank_e_pin_i,    // bank e pin levels
	output logic [E_W-1:0]         bank_e_pin_o,    // bank e pin drive
	output logic [E_W-1:0]         bank_e_pin_oe,   // bank e drive enable
	input  wire logic              bank_e_input_only_pin, // input-only pin level
	input  wire logic              master_clear_enable_cfg, // strap, 1 = clear pin
	output logic                   master_clear_req, // clear request, active high
	input  wire pde_pwm_in_t       pwm_in,          // pwm engine outputs
	input  wire logic              slave_host_read, // host reading slave bus
	input  wire logic              input_buffer_full,  // slave input word held
	input  wire logic              output_buffer_full, // slave output word held
	input  wire logic              slave_overflow,  // overflow pulse
	output logic                   parallel_slave_bus_active, // slave bus enabled
	output logic [D_W-1:0]         parallel_slave_bus_wdata,  // host write data
	output logic                   irq              // interrupt, active high
);

	logic [D_W-1:0] d_sync1_reg;
	logic [D_W-1:0] d_sync2_reg;
	logic [E_W-1:0] e_sync1_reg;
	logic [E_W-1:0] e_sync2_reg;
	logic           iop_sync1_reg;
	logic           iop_sync2_reg;
	logic           iop_prev_reg;
	logic           mclr_en_reg;
	logic [2:0]     fill_reg;
	logic [D_W-1:0] d_latch_reg;
	logic [D_W-1:0] d_dir_reg;
	logic [E_W-1:0] e_latch_reg;
	logic [E_W-1:0] e_dir_reg;
	logic           slave_mode_reg;
	logic           in_ovf_reg;
	logic [7:0]     pwm_ctl_reg;
	logic           pwm_tri_cfg_reg;
	logic [E_W-1:0] ana_sel_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic           shdn_prev_reg;
	logic [DATA_W-1:0] rdata_next;
	logic           err_next;
	logic           mapped;
	logic           setup_ph;
	logic           wr_en;
	logic [7:0]     wbyte;
	logic           pwm_mode;
	logic           pwm_multi;
	logic           pwm_cd;
	logic [D_W-1:0] pwm_own;
	logic [D_W-1:0] pwm_val;
	logic           pwm_tri;
	logic           slave_active;
	logic           pin_digital;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	// two-stage synchronisers on all pin inputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_sync1_reg   <= '0;
			d_sync2_reg   <= '0;
			e_sync1_reg   <= '0;
			e_sync2_reg   <= '0;
			iop_sync1_reg <= 1'b0;
			iop_sync2_reg <= 1'b0;
		end else begin
			d_sync1_reg   <= bank_d_pin_i;
			d_sync2_reg   <= d_sync1_reg;
			e_sync1_reg   <= bank_e_pin_i;
			e_sync2_reg   <= e_sync1_reg;
			iop_sync1_reg <= bank_e_input_only_pin;
			iop_sync2_reg <= iop_sync1_reg;
		end
	end

	// strap caught once; fill_reg holds off pin use until the synchroniser carries real levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mclr_en_reg <= 1'b1;
			fill_reg    <= 3'h0;
		end else begin
			fill_reg <= {fill_reg[1:0], 1'b1};
			if (!fill_reg[0]) begin
				mclr_en_reg <= master_clear_enable_cfg;
			end
		end
	end

	assign pin_digital      = fill_reg[0] & ~mclr_en_reg;
	assign master_clear_req = fill_reg[1] & mclr_en_reg & ~iop_sync2_reg;

	// apb decode
	assign setup_ph = apb_req.psel & ~apb_req.penable;
	assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped;
	assign wbyte    = apb_req.pwdata[7:0];
	assign pready   = 1'b1;

	always_comb begin
		case (apb_req.paddr)
			OFS_D_PIN,
			OFS_D_LATCH,
			OFS_D_DIR,
			OFS_E_DIRCTL,
			OFS_E_PIN,
			OFS_E_LATCH,
			OFS_PWM_CTL,
			OFS_PWM_CFG,
			OFS_ANA_SEL,
			OFS_INT_STAT,
			OFS_INT_MASK: mapped = 1'b1;
			default:      mapped = 1'b0;
		endcase
	end

	// pwm steering
	assign pwm_mode  = (pwm_ctl_reg[PWM_MOD_HI:PWM_MOD_LO] == PWM_MODE_PWM);
	assign pwm_multi = pwm_mode & (pwm_ctl_reg[PWM_P1M_HI:PWM_P1M_LO] != P1M_SINGLE);
	assign pwm_cd    = pwm_mode & pwm_ctl_reg[PWM_P1M_LO];
	assign pwm_tri   = pwm_tri_cfg_reg & pwm_in.shutdown;

	always_comb begin
		pwm_own            = '0;
		pwm_val            = '0;
		pwm_own[PWM_B_PIN] = pwm_multi;
		pwm_own[PWM_C_PIN] = pwm_cd;
		pwm_own[PWM_D_PIN] = pwm_cd;
		pwm_val[PWM_B_PIN] = pwm_in.pwm_b;
		pwm_val[PWM_C_PIN] = pwm_in.pwm_c;
		pwm_val[PWM_D_PIN] = pwm_in.pwm_d;
	end

	assign slave_active              = slave_mode_reg & ~pwm_multi;
	assign parallel_slave_bus_active = slave_active;
	assign parallel_slave_bus_wdata  = d_sync2_reg;

	// bank d latch and direction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_latch_reg <= RST_D_LATCH;
		end else if (wr_en && (apb_req.paddr == OFS_D_PIN || apb_req.paddr == OFS_D_LATCH)) begin
			d_latch_reg <= wbyte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_dir_reg <= RST_D_DIR;
		end else if (wr_en && apb_req.paddr == OFS_D_DIR) begin
			d_dir_reg <= wbyte;
		end
	end

	// bank e latch, direction and slave control
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			e_latch_reg <= RST_E_LATCH;
		end else if (wr_en && (apb_req.paddr == OFS_E_PIN || apb_req.paddr == OFS_E_LATCH)) begin
			e_latch_reg <= wbyte[E_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			e_dir_reg      <= RST_E_DIR;
			slave_mode_reg <= 1'b0;
		end else if (wr_en && apb_req.paddr == OFS_E_DIRCTL) begin
			e_dir_reg      <= wbyte[E_W-1:0];
			slave_mode_reg <= wbyte[E_MODE_BIT];
		end
	end

	// overflow flag: hardware set wins over software clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_ovf_reg <= 1'b0;
		end else if (slave_overflow && slave_active) begin
			in_ovf_reg <= 1'b1;
		end else if (wr_en && apb_req.paddr == OFS_E_DIRCTL && !wbyte[E_INOVF_BIT]) begin
			in_ovf_reg <= 1'b0;
		end
	end

	// pwm and analog configuration
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_ctl_reg     <= RST_PWM_CTL;
			pwm_tri_cfg_reg <= RST_PWM_CFG;
		end else if (wr_en) begin
			if (apb_req.paddr == OFS_PWM_CTL) begin
				pwm_ctl_reg <= wbyte;
			end
			if (apb_req.paddr == OFS_PWM_CFG) begin
				pwm_tri_cfg_reg <= wbyte[0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ana_sel_reg <= RST_ANA_SEL;
		end else if (wr_en && apb_req.paddr == OFS_ANA_SEL) begin
			ana_sel_reg <= wbyte[E_W-1:0];
		end
	end

	// interrupt events
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shdn_prev_reg <= 1'b0;
			iop_prev_reg  <= 1'b0;
		end else begin
			shdn_prev_reg <= pwm_in.shutdown;
			iop_prev_reg  <= iop_sync2_reg;
		end
	end

	always_comb begin
		irq_set               = '0;
		irq_set[IRQ_OVF_BIT]  = slave_overflow & slave_active;
		irq_set[IRQ_SHDN_BIT] = pwm_in.shutdown & ~shdn_prev_reg;
		irq_set[IRQ_IOP_BIT]  = pin_digital & fill_reg[2] & (iop_sync2_reg ^ iop_prev_reg);
	end

	assign irq_clr = (wr_en && apb_req.paddr == OFS_INT_STAT) ? wbyte[IRQ_W-1:0] : '0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= RST_IRQ;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_reg <= RST_IRQ;
		end else if (wr_en && apb_req.paddr == OFS_INT_MASK) begin
			irq_mask_reg <= wbyte[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// read mux; unimplemented bits read zero
	always_comb begin
		rdata_next = '0;
		err_next   = ~mapped;
		case (apb_req.paddr)
			OFS_D_PIN: begin
				rdata_next[D_W-1:0] = d_sync2_reg;
			end
			OFS_D_LATCH: begin
				rdata_next[D_W-1:0] = d_latch_reg;
			end
			OFS_D_DIR: begin
				rdata_next[D_W-1:0] = d_dir_reg;
			end
			OFS_E_DIRCTL: begin
				rdata_next[E_INFULL_BIT]  = input_buffer_full;
				rdata_next[E_OUTFULL_BIT] = output_buffer_full;
				rdata_next[E_INOVF_BIT]   = in_ovf_reg;
				rdata_next[E_MODE_BIT] = slave_mode_reg;
				rdata_next[E_W-1:0]    = e_dir_reg;
			end
			OFS_E_PIN: begin
				rdata_next[E_W-1:0] = e_sync2_reg & ~ana_sel_reg;
				rdata_next[E_W]     = pin_digital & iop_sync2_reg;
			end
			OFS_E_LATCH: begin
				rdata_next[E_W-1:0] = e_latch_reg;
			end
			OFS_PWM_CTL: begin
				rdata_next[7:0] = pwm_ctl_reg;
			end
			OFS_PWM_CFG: begin
				rdata_next[0] = pwm_tri_cfg_reg;
			end
			OFS_ANA_SEL: begin
				rdata_next[E_W-1:0] = ana_sel_reg;
			end
			OFS_INT_STAT: begin
				rdata_next[IRQ_W-1:0] = irq_stat_reg;
			end
			OFS_INT_MASK: begin
				rdata_next[IRQ_W-1:0] = irq_mask_reg;
			end
			default: rdata_next = '0;
		endcase
	end

	// read data and error are taken in the setup cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata  <= apb_req.pwrite ? '0 : rdata_next;
			pslverr <= err_next;
		end
	end

	// pin drivers
	genvar gi;
	generate
		for (gi = 0; gi < D_W; gi++) begin : g_d
			pde_pin_cell u_cell (
				.sys_clk      (sys_clk),
				.rst_n        (rst_n),
				.latch_bit    (d_latch_reg[gi]),
				.dir_bit      (d_dir_reg[gi]),
				.slave_active (slave_active),
				.slave_rd     (slave_host_read),
				.pwm_en       (pwm_own[gi]),
				.pwm_val      (pwm_val[gi]),
				.pwm_tri      (pwm_tri),
				.pin_o        (bank_d_pin_o[gi]),
				.pin_oe       (bank_d_pin_oe[gi])
			);
		end
		for (gi = 0; gi < E_W; gi++) begin : g_e
			pde_pin_cell u_cell (
				.sys_clk      (sys_clk),
				.rst_n        (rst_n),
				.latch_bit    (e_latch_reg[gi]),
				.dir_bit      (e_dir_reg[gi]),
				.slave_active (1'b0),
				.slave_rd     (1'b0),
				.pwm_en       (1'b0),
				.pwm_val      (1'b0),
				.pwm_tri      (1'b0),
				.pin_o        (bank_e_pin_o[gi]),
				.pin_oe       (bank_e_pin_oe[gi])
			);
		end
	endgenerate

endmodule

// >>> testbench/pde_pin_model.sv
`timescale 1ns/100ps
module pde_pin_model
	import pde_pkg::*;
(
	input  wire logic [D_W-1:0] d_o,   // design drive
	input  wire logic [D_W-1:0] d_oe,  // design enable
	input  wire logic [D_W-1:0] ext_d, // outside level
	input  wire logic [E_W-1:0] e_o,   // design drive
	input  wire logic [E_W-1:0] e_oe,  // design enable
	input  wire logic [E_W-1:0] ext_e, // outside level
	output logic      [D_W-1:0] d_i,   // pin level
	output logic      [E_W-1:0] e_i    // pin level
);
	// outside circuitry yields wherever the design drives
	assign d_i = (d_o & d_oe) | (ext_d & ~d_oe);
	assign e_i = (e_o & e_oe) | (ext_e & ~e_oe);
endmodule

// >>> testbench/pde_port_ctl_sva.sv
`timescale 1ns/100ps
module pde_port_ctl_chk
	import pde_pkg::*;
(
	input wire logic              sys_clk,                   // clock
	input wire logic              rst_n,                     // reset
	input wire pde_apb_req_t      apb_req,                   // apb
	input wire logic              pready,                    // apb
	input wire logic [DATA_W-1:0] prdata,                    // apb
	input wire logic              pslverr,                   // apb
	input wire logic [D_W-1:0]    bank_d_pin_i,              // pins
	input wire logic [D_W-1:0]    bank_d_pin_o,              // pins
	input wire logic [D_W-1:0]    bank_d_pin_oe,             // pins
	input wire logic [E_W-1:0]    bank_e_pin_o,              // pins
	input wire logic [E_W-1:0]    bank_e_pin_oe,             // pins
	input wire pde_pwm_in_t       pwm_in,                    // pwm
	input wire logic              slave_host_read,           // slave
	input wire logic              parallel_slave_bus_active, // slave
	input wire logic [D_W-1:0]    parallel_slave_bus_wdata,  // slave
	input wire logic              irq                        // irq
);
	logic [7:0]     m [0:10];
	logic [3:0]     wi;
	logic           mapped, rd, own5, own67, tri_n;
	logic [D_W-1:0] exp_oe, exp_o;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// shadow of the written registers
	assign wi = (apb_req.paddr == OFS_D_PIN) ? 4'h1 : (apb_req.paddr == OFS_E_PIN) ? 4'h5 : apb_req.paddr[5:2];
	assign mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= OFS_INT_MASK;
	assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			m <= '{8'h00, 8'h00, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
		end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && mapped) begin
			m[wi] <= apb_req.pwdata[7:0];
		end
	end
	assign own5 = m[6][3:2] == PWM_MODE_PWM && m[6][7:6] != P1M_SINGLE;
	assign own67 = m[6][3:2] == PWM_MODE_PWM && m[6][6];
	assign tri_n = !(m[7][0] && pwm_in.shutdown);
	always_comb begin
		for (int i = 0; i < D_W; i++) begin
			exp_oe[i] = (m[3][4] && !own5) ? slave_host_read : !m[2][i];
		end
		exp_o = m[1];
		if (own5) begin
			exp_oe[PWM_B_PIN] = tri_n;
			exp_o[PWM_B_PIN] = pwm_in.pwm_b;
		end
		if (own67) begin
			exp_oe[7:6] = {2{tri_n}};
			exp_o[7:6] = {pwm_in.pwm_d, pwm_in.pwm_c};
		end
	end
	AST_PREADY: assert property (pready)
		else $error("pready low");
	AST_ERR: assert property (apb_req.psel && !apb_req.penable |=> pslverr == !$past(mapped))
		else $error("pslverr wrong");
	AST_D_OE: assert property (bank_d_pin_oe == $past(exp_oe))
		else $error("bank d enable wrong");
	AST_D_OUT: assert property (bank_d_pin_o == $past(exp_o))
		else $error("bank d drive wrong");
	AST_E_PINS: assert property (bank_e_pin_oe == ~$past(m[3][2:0]) && bank_e_pin_o == $past(m[5][2:0]))
		else $error("bank e pins wrong");
	AST_SLAVE: assert property (parallel_slave_bus_active == (m[3][4] && !own5))
		else $error("slave bus enable wrong");
	AST_ANALOG: assert property (rd && apb_req.paddr == OFS_E_PIN |-> (prdata[2:0] & m[8][2:0]) == 3'h0)
		else $error("analog pin not zero");
	AST_ECTL: assert property (rd && apb_req.paddr == OFS_E_DIRCTL |-> prdata[31:8] == 24'h0 && !prdata[3] && prdata[4] == m[3][4] && prdata[2:0] == m[3][2:0])
		else $error("bank e control read wrong");
	AST_LATCH: assert property (rd && apb_req.paddr == OFS_E_LATCH |-> prdata == {29'h0, m[5][2:0]})
		else $error("bank e latch read wrong");
	AST_WDATA: assert property ($stable(bank_d_pin_i) [*4] |-> parallel_slave_bus_wdata == bank_d_pin_i)
		else $error("slave write data wrong");
	AST_IRQ: assert property (m[10][IRQ_W-1:0] == 3'h0 |-> !irq)
		else $error("irq while masked");
endmodule

bind pde_port_ctl pde_port_ctl_chk i_chk (.sys_clk, .rst_n, .apb_req, .pready, .prdata, .pslverr, .bank_d_pin_i,
	.bank_d_pin_o, .bank_d_pin_oe, .bank_e_pin_o, .bank_e_pin_oe, .pwm_in, .slave_host_read,
	.parallel_slave_bus_active, .parallel_slave_bus_wdata, .irq);

// >>> testbench/port_d_e_pin_control_bench.sv
`timescale 1ns/100ps
module port_d_e_pin_control_bench;
	import pde_pkg::*;
	typedef struct packed {logic [31:0] d; logic e;} pde_note_t;
	logic         sys_clk = 1'b0;
	logic         rst_n = 1'b0;
	pde_apb_req_t req = '0;
	pde_pwm_in_t  pw = '0;
	logic [7:0]   ext_d = 8'h5A;
	logic [2:0]   ext_e = 3'h2;
	logic         in_full = 1'b1, out_full = 1'b0, ovf = 1'b0, shr = 1'b0, iop = 1'b0, strap = 1'b0;
	logic         pready, pslverr, irq, psb, mcr;
	logic [31:0]  prdata, r, v, w, seed = 32'hAE78;
	logic [7:0]   d_i, d_o, d_oe, wd;
	logic [2:0]   e_i, e_o, e_oe;
	pde_note_t    q[$];
	pde_note_t    n;
	int           fail_count = 0, num_checks = 0;
	logic [31:0]  rv [12] = '{32'h5A, 32'h0, 32'hFF, 32'h87, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0};

	always #2 sys_clk = ~sys_clk;

	pde_port_ctl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bank_d_pin_i(d_i), .bank_d_pin_o(d_o), .bank_d_pin_oe(d_oe), .bank_e_pin_i(e_i),
		.bank_e_pin_o(e_o), .bank_e_pin_oe(e_oe), .bank_e_input_only_pin(iop), .master_clear_enable_cfg(strap),
		.master_clear_req(mcr), .pwm_in(pw), .slave_host_read(shr), .input_buffer_full(in_full),
		.output_buffer_full(out_full), .slave_overflow(ovf), .parallel_slave_bus_active(psb),
		.parallel_slave_bus_wdata(wd), .irq(irq));
	pde_pin_model i_pins (.d_o(d_o), .d_oe(d_oe), .ext_d(ext_d), .e_o(e_o), .e_oe(e_oe), .ext_e(ext_e),
		.d_i(d_i), .e_i(e_i));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmp(input string s, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		q.push_back({e, er});
		@(posedge sys_clk);
		req.penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic pins(input logic [7:0] oe, o, input logic [2:0] eoe, eo);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		cmp("d_oe", 32'(d_oe), 32'(oe));
		cmp("d_o", 32'(d_o), 32'(o));
		cmp("e_oe", 32'(e_oe), 32'(eoe));
		cmp("e_o", 32'(e_o), 32'(eo));
		@(posedge sys_clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// each finished transfer answers the oldest note
	always @(posedge sys_clk) begin
		if (req.psel && req.penable && pready === 1'b1 && q.size() > 0) begin
			n = q.pop_front();
			cmp("prdata", prdata, n.d);
			cmp("pslverr", 32'(pslverr), 32'(n.e));
		end
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 12; i++) apb(1'b0, 8'(i * 4), 32'h0, rv[i], i == 11);
		$display("reset values done");
		r = xs();
		v = xs();
		apb(1'b1, OFS_D_DIR, r, 32'h0, 1'b0);
		apb(1'b1, OFS_D_PIN, v, 32'h0, 1'b0);
		pins(~r[7:0], v[7:0], 3'h0, 3'h0);
		apb(1'b0, OFS_D_PIN, 32'h0, {24'h0, (v[7:0] & ~r[7:0]) | (ext_d & r[7:0])}, 1'b0);
		apb(1'b0, OFS_D_LATCH, 32'h0, {24'h0, v[7:0]}, 1'b0);
		$display("bank d gpio done");
		apb(1'b1, OFS_ANA_SEL, 32'h0, 32'h0, 1'b0);
		apb(1'b1, OFS_E_DIRCTL, 32'hFA, 32'h0, 1'b0);
		apb(1'b1, OFS_E_LATCH, 32'h5, 32'h0, 1'b0);
		pins(8'h00, v[7:0], 3'h5, 3'h5);
		cmp("wdata", 32'(wd), 32'(ext_d));
		apb(1'b0, OFS_E_DIRCTL, 32'h0, 32'h92, 1'b0);
		apb(1'b0, OFS_E_PIN, 32'h0, 32'h7, 1'b0);
		apb(1'b0, OFS_E_LATCH, 32'h0, 32'h5, 1'b0);
		apb(1'b1, OFS_ANA_SEL, 32'h1, 32'h0, 1'b0);
		apb(1'b0, OFS_E_PIN, 32'h0, 32'h6, 1'b0);
		shr <= 1'b1;
		pins(8'hFF, v[7:0], 3'h5, 3'h5);
		$display("bank e and slave bus done");
		ovf <= 1'b1;
		out_full <= 1'b1;
		@(posedge sys_clk);
		ovf <= 1'b0;
		apb(1'b0, OFS_E_DIRCTL, 32'h0, 32'hF2, 1'b0);
		apb(1'b0, OFS_INT_STAT, 32'h0, 32'h1, 1'b0);
		cmp("irq", 32'(irq), 32'h0);
		apb(1'b1, OFS_INT_MASK, 32'h1, 32'h0, 1'b0);
		cmp("irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_INT_STAT, 32'h1, 32'h0, 1'b0);
		cmp("irq", 32'(irq), 32'h0);
		apb(1'b1, OFS_E_DIRCTL, 32'h12, 32'h0, 1'b0);
		apb(1'b0, OFS_E_DIRCTL, 32'h0, 32'hD2, 1'b0);
		iop <= 1'b1;
		repeat (4) @(posedge sys_clk);
		apb(1'b0, OFS_INT_STAT, 32'h0, 32'h4, 1'b0);
		apb(1'b0, OFS_E_PIN, 32'h0, 32'hE, 1'b0);
		$display("interrupts done");
		shr <= 1'b0;
		w = xs();
		pw <= {w[2:0], 1'b0};
		apb(1'b1, OFS_PWM_CFG, 32'h1, 32'h0, 1'b0);
		apb(1'b1, OFS_PWM_CTL, 32'hCC, 32'h0, 1'b0);
		pins({3'h7, ~r[4:0]}, {pw.pwm_d, pw.pwm_c, pw.pwm_b, v[4:0]}, 3'h5, 3'h5);
		cmp("slave active", 32'(psb), 32'h0);
		pw.shutdown <= 1'b1;
		pins({3'h0, ~r[4:0]}, {pw.pwm_d, pw.pwm_c, pw.pwm_b, v[4:0]}, 3'h5, 3'h5);
		$display("pwm done");
		strap <= 1'b1;
		pw <= '0;
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cmp("clear req", 32'(mcr), 32'h0);
		apb(1'b0, OFS_E_PIN, 32'h0, 32'h0, 1'b0);
		iop <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cmp("clear req", 32'(mcr), 32'h1);
		apb(1'b0, OFS_INT_STAT, 32'h0, 32'h0, 1'b0);
		$display("master clear done");
		conclude();
	end
endmodule
